//--- shared/rtv_pkg.sv
package rtv_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] RTV_OFF_CFG     = 8'h00;
  localparam logic [7:0] RTV_OFF_RTADDR  = 8'h04;
  localparam logic [7:0] RTV_OFF_LASTCMD = 8'h08;
  localparam logic [7:0] RTV_OFF_VSTAT   = 8'h0C;
  localparam logic [7:0] RTV_OFF_COUNT   = 8'h10;

  // option bit positions in the configuration register
  localparam int RTV_CFG_BCST_INV   = 4;
  localparam int RTV_CFG_UMC_INV    = 3;
  localparam int RTV_CFG_SEP_BCST   = 2;
  localparam int RTV_CFG_SIMPLE_MC  = 1;
  localparam int RTV_CFG_SS_READ8   = 0;
  localparam int RTV_CFG_W          = 5;

  // field positions in the validation status register
  localparam int RTV_VS_MSG_ERR     = 0;
  localparam int RTV_VS_BCAST       = 1;
  localparam int RTV_VS_UNDEF       = 2;

  // reset values
  localparam logic [4:0]  RTV_CFG_RST     = 5'h00;
  localparam logic [4:0]  RTV_RTADDR_RST  = 5'h00;
  localparam logic [15:0] RTV_LASTCMD_RST = 16'h0000;
  localparam logic [15:0] RTV_COUNT_RST   = 16'h0000;

  // command word fields and codes
  localparam logic [4:0] RTV_BCAST_ADDR  = 5'h1F;
  localparam logic [4:0] RTV_SA_MODE_LO  = 5'h00;
  localparam logic [4:0] RTV_SA_MODE_HI  = 5'h1F;
  localparam logic [4:0] RTV_MC_RX_MAX   = 5'h0F;
  localparam logic [4:0] RTV_MC_RX_16    = 5'h10;
  localparam logic [4:0] RTV_MC_RX_18    = 5'h12;
  localparam logic [4:0] RTV_MC_RX_19    = 5'h13;
  localparam logic [4:0] RTV_MC_TX_17    = 5'h11;
  localparam logic [4:0] RTV_MC_TX_20    = 5'h14;
  localparam logic [4:0] RTV_MC_TX_21    = 5'h15;

  // host pin synchroniser width: strobe, byte select, bus width strap
  localparam int RTV_PIN_W = 3;

  typedef enum logic [1:0] {
    RTV_VS_IDLE = 2'b01,
    RTV_VS_EVAL = 2'b10
  } rtv_vstate_t;

endpackage : rtv_pkg

//--- hw/rtv_sync2.sv
`timescale 1ns/10ps
module rtv_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,  // device clock
  input  wire logic         rstn,  // async reset, active low
  input  wire logic [W-1:0] d,     // asynchronous level
  output logic      [W-1:0] q      // level in the mclk domain
);
  logic [W-1:0] meta_q;

  // first stage feeds the second stage only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : rtv_sync2

//--- hw/rtv_byte_read.sv
`timescale 1ns/10ps
module rtv_byte_read (
  input  wire logic        mclk,       // device clock
  input  wire logic        rstn,       // async reset, active low
  input  wire logic        strobe,     // synchronised read strobe, active high
  input  wire logic        byte_sel,   // synchronised byte select, high = upper byte
  input  wire logic        single_en,  // single wide strobe serves both bytes
  input  wire logic [15:0] word,       // word being read
  output logic      [7:0]  byte_q      // byte presented to the host
);
  logic strobe_q;
  logic [7:0] pick;

  assign pick = byte_sel ? word[15:8] : word[7:0];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe;
    end
  end

  // dual strobe: one byte per strobe, latched at its start
  // single strobe: byte follows the select bit while the strobe is held
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      byte_q <= 8'h00;
    end else if (single_en && strobe) begin
      byte_q <= pick; // R10
    end else if (strobe && !strobe_q) begin
      byte_q <= pick;
    end
  end
endmodule : rtv_byte_read

//--- hw/rtv_cmd_validate.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// R1: option set: address 31 commands ignored silently
// R2: option clear: address 31 is valid broadcast
// R3: undefined set is limited to listed codes
// R4: option clear: undefined legal gets in-form response
// R5: undefined illegal: message error, status only
// R6: option set: undefined codes ignored, no update
// R7: option set: broadcast data to separate store
// R8: option clear: broadcast data shares normal buffer
// R9: option set: simplified handling for valid modes
// R10: single strobe serves two-byte read on 8-bit
// R11: host sets single-strobe before any readback
// R12: master reset clears all five options
// R13: options sampled when each command is validated
module rtv_cmd_validate
  import rtv_pkg::*;
(
  input  wire logic        mclk,               // device clock, 25 MHz
  input  wire logic        rstn,               // master reset, active low
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb enable
  input  wire logic [7:0]  paddr,              // apb byte address
  input  wire logic        pwrite,             // apb direction, high = write
  input  wire logic [31:0] pwdata,             // apb write data
  output logic      [31:0] prdata,             // apb read data
  output logic             pready,             // apb ready
  output logic             pslverr,            // apb error, unmapped address
  input  wire logic        cmd_strobe,         // command word received, one cycle
  input  wire logic [15:0] cmd_word,           // received command word
  input  wire logic        cmd_illegal,        // illegalization entry for the command
  input  wire logic        host_rd_strobe_n,   // host read strobe pin, active low
  input  wire logic        byte_select_address_bit, // host byte select pin
  input  wire logic        host_bus_8bit,      // bus width strap pin, high = 8 bit
  input  wire logic [15:0] host_rd_word,       // word addressed by the host
  output logic      [7:0]  host_rd_byte,       // byte driven to the host
  output logic             cmd_recognized,     // command accepted, pulse
  output logic             cmd_respond,        // send status word, pulse
  output logic             cmd_status_only,    // respond without data words, pulse
  output logic             cmd_msg_error,      // message error status bit, level
  output logic             cmd_status_update,  // update reported status, pulse
  output logic             cmd_bcast_sep,      // store data in broadcast area, pulse
  output logic             cmd_simplified,     // simplified mode handling, pulse
  output logic             broadcast_invalid_option,          // level
  output logic             undefined_mode_invalid_option,     // level
  output logic             separate_broadcast_data_option,    // level
  output logic             simplified_mode_processing_option, // level
  output logic             single_strobe_byte_read_option     // level
);

  logic [RTV_CFG_W-1:0] cfg_q;
  logic [4:0]           rtaddr_q;
  logic [15:0]          lastcmd_q;
  logic [2:0]           vstat_q;
  logic [15:0]          cnt_ok_q;
  logic [15:0]          cnt_ign_q;

  logic                 apb_setup;
  logic                 apb_wr;
  logic [31:0]          rd_mux;
  logic                 rd_hit;

  rtv_vstate_t          state_q;
  logic [15:0]          word_q;
  logic                 illegal_q;
  logic [RTV_CFG_W-1:0] opt_q;

  logic [4:0]           f_addr;
  logic                 f_tr;
  logic [4:0]           f_sa;
  logic [4:0]           f_mc;
  logic                 is_bcast;
  logic                 to_me;
  logic                 is_mode;
  logic                 is_undef;
  logic                 addr_ok;
  logic                 valid;
  logic                 judge;
  logic                 drop;

  logic [RTV_PIN_W-1:0] pin_raw;
  logic [RTV_PIN_W-1:0] pin_sync;
  logic                 single_en;

  // ---------------- apb slave ----------------
  // no wait state: prdata, pready and pslverr leave flops loaded in the setup cycle
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      RTV_OFF_CFG:     rd_mux[RTV_CFG_W-1:0] = cfg_q;
      RTV_OFF_RTADDR:  rd_mux[4:0]           = rtaddr_q;
      RTV_OFF_LASTCMD: rd_mux[15:0]          = lastcmd_q;
      RTV_OFF_VSTAT:   rd_mux[2:0]           = vstat_q;
      RTV_OFF_COUNT:   rd_mux                = {cnt_ign_q, cnt_ok_q};
      default:         rd_hit                = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_setup;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !rd_hit;
    end else begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // configuration options: written over apb, all cleared by master reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= RTV_CFG_RST; // R12
    end else if (apb_wr && paddr == RTV_OFF_CFG) begin
      cfg_q <= pwdata[RTV_CFG_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rtaddr_q <= RTV_RTADDR_RST;
    end else if (apb_wr && paddr == RTV_OFF_RTADDR) begin
      rtaddr_q <= pwdata[4:0];
    end
  end

  // option levels exported to the buffer and mode logic, one cycle behind cfg
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      broadcast_invalid_option <= 1'b0; // R12
    end else begin
      broadcast_invalid_option <= cfg_q[RTV_CFG_BCST_INV];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      undefined_mode_invalid_option <= 1'b0; // R12
    end else begin
      undefined_mode_invalid_option <= cfg_q[RTV_CFG_UMC_INV];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      separate_broadcast_data_option <= 1'b0; // R12
    end else begin
      separate_broadcast_data_option <= cfg_q[RTV_CFG_SEP_BCST];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      simplified_mode_processing_option <= 1'b0; // R12
    end else begin
      simplified_mode_processing_option <= cfg_q[RTV_CFG_SIMPLE_MC];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      single_strobe_byte_read_option <= 1'b0; // R12
    end else begin
      single_strobe_byte_read_option <= cfg_q[RTV_CFG_SS_READ8];
    end
  end

  // ---------------- command validation ----------------
  // a strobe arriving while a word is still being judged is dropped;
  // bus words are microseconds apart so this never happens in service
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= RTV_VS_IDLE;
    end else begin
      case (state_q)
        RTV_VS_IDLE: begin
          if (cmd_strobe) begin
            state_q <= RTV_VS_EVAL;
          end
        end
        RTV_VS_EVAL: state_q <= RTV_VS_IDLE;
        default:     state_q <= RTV_VS_IDLE;
      endcase
    end
  end

  // snapshot of the word and the options: a host write mid-check waits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      word_q    <= 16'h0000;
      illegal_q <= 1'b0;
      opt_q     <= RTV_CFG_RST;
    end else if (state_q == RTV_VS_IDLE && cmd_strobe) begin
      word_q    <= cmd_word;
      illegal_q <= cmd_illegal;
      opt_q     <= cfg_q; // R13
    end
  end

  assign f_addr   = word_q[15:11];
  assign f_tr     = word_q[10];
  assign f_sa     = word_q[9:5];
  assign f_mc     = word_q[4:0];
  assign is_bcast = (f_addr == RTV_BCAST_ADDR);
  assign to_me    = (f_addr == rtaddr_q);
  assign is_mode  = (f_sa == RTV_SA_MODE_LO) || (f_sa == RTV_SA_MODE_HI);

  // only these receive and transmit codes count as undefined
  assign is_undef = is_mode && (
      (!f_tr && (f_mc <= RTV_MC_RX_MAX)) ||
      (!f_tr && (f_mc == RTV_MC_RX_16 || f_mc == RTV_MC_RX_18 ||
                 f_mc == RTV_MC_RX_19)) ||
      (f_tr && (f_mc == RTV_MC_TX_17 || f_mc == RTV_MC_TX_20 ||
                f_mc == RTV_MC_TX_21))); // R3

  // own address 31 collides with broadcast and is handled as broadcast
  assign addr_ok = is_bcast ? !opt_q[RTV_CFG_BCST_INV] : to_me; // R1 R2
  assign valid   = addr_ok && !(is_undef && opt_q[RTV_CFG_UMC_INV]); // R6 R4
  assign judge   = (state_q == RTV_VS_EVAL) && valid;
  assign drop    = (state_q == RTV_VS_EVAL) && !valid;

  // per-command pulses, high for the single cycle after the check
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_recognized <= 1'b0;
    end else begin
      cmd_recognized <= judge; // R1 R2
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_respond <= 1'b0;
    end else begin
      cmd_respond <= judge && !is_bcast; // R1
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_status_only <= 1'b0;
    end else begin
      cmd_status_only <= judge && !is_bcast && illegal_q; // R5
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_status_update <= 1'b0;
    end else begin
      cmd_status_update <= judge; // R6 R4
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_bcast_sep <= 1'b0;
    end else begin
      cmd_bcast_sep <= judge && is_bcast && opt_q[RTV_CFG_SEP_BCST]; // R7 R8
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_simplified <= 1'b0;
    end else begin
      cmd_simplified <= judge && is_mode && opt_q[RTV_CFG_SIMPLE_MC]; // R9
    end
  end

  // reported status moves only for recognised commands, so an ignored
  // word never disturbs what transmit-status or last-command returns
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_msg_error <= 1'b0;
    end else if (judge) begin
      cmd_msg_error <= illegal_q; // R5 R4
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lastcmd_q <= RTV_LASTCMD_RST;
    end else if (judge) begin
      lastcmd_q <= word_q; // R1 R6
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vstat_q <= 3'h0;
    end else if (judge) begin
      vstat_q[RTV_VS_MSG_ERR] <= illegal_q;
      vstat_q[RTV_VS_BCAST]   <= is_bcast;
      vstat_q[RTV_VS_UNDEF]   <= is_undef;
    end
  end

  // counters saturate rather than wrap so a long soak stays readable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ok_q <= RTV_COUNT_RST;
    end else if (judge && cnt_ok_q != 16'hFFFF) begin
      cnt_ok_q <= cnt_ok_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ign_q <= RTV_COUNT_RST;
    end else if (drop && cnt_ign_q != 16'hFFFF) begin
      cnt_ign_q <= cnt_ign_q + 16'h0001;
    end
  end

  // ---------------- host byte read path ----------------
  assign pin_raw = {host_bus_8bit, byte_select_address_bit, !host_rd_strobe_n};

  rtv_sync2 #(
    .W (RTV_PIN_W)
  ) u_pin_sync (
    .mclk (mclk),
    .rstn (rstn),
    .d    (pin_raw),
    .q    (pin_sync)
  );

  // the option only matters on the narrow bus; host sets it before readback
  assign single_en = cfg_q[RTV_CFG_SS_READ8] && pin_sync[2]; // R10 R11

  rtv_byte_read u_byte_read (
    .mclk      (mclk),
    .rstn      (rstn),
    .strobe    (pin_sync[0]),
    .byte_sel  (pin_sync[1]),
    .single_en (single_en),
    .word      (host_rd_word),
    .byte_q    (host_rd_byte)
  );

endmodule : rtv_cmd_validate

//--- bench/rtv_bc_model.sv
`timescale 1ns/10ps
module rtv_bc_model (
  input  wire logic        mclk,        // device clock
  output logic             cmd_strobe,  // word valid, one cycle
  output logic      [15:0] cmd_word,    // command word
  output logic             cmd_illegal  // table entry for the word
);
  initial begin
    cmd_strobe = 1'b0;
    cmd_word = 16'h0000;
    cmd_illegal = 1'b0;
  end

  // lines carry the inverse between words, so a stale word never looks valid
  task automatic send(input logic [15:0] w, input logic il);
    @(posedge mclk);
    cmd_strobe <= 1'b1;
    cmd_word <= w;
    cmd_illegal <= il;
    @(posedge mclk);
    cmd_strobe <= 1'b0;
    cmd_word <= ~w;
    cmd_illegal <= ~il;
  endtask : send
endmodule : rtv_bc_model

//--- bench/rtv_cmd_validate_properties.sv
`timescale 1ns/10ps
module rtv_cmd_validate_chk (
  input wire logic        mclk,                              // clock
  input wire logic        rstn,                              // reset
  input wire logic        cmd_strobe,                        // word in
  input wire logic [15:0] cmd_word,                          // word
  input wire logic        cmd_illegal,                       // table entry
  input wire logic        cmd_recognized,                    // pulse
  input wire logic        cmd_respond,                       // pulse
  input wire logic        cmd_status_only,                   // pulse
  input wire logic        cmd_msg_error,                     // level
  input wire logic        cmd_status_update,                 // pulse
  input wire logic        cmd_bcast_sep,                     // pulse
  input wire logic        cmd_simplified,                    // pulse
  input wire logic        broadcast_invalid_option,          // level
  input wire logic        undefined_mode_invalid_option,     // level
  input wire logic        separate_broadcast_data_option,    // level
  input wire logic        simplified_mode_processing_option  // level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  wire logic [4:0] mc = cmd_word[4:0];
  wire logic       bc = cmd_word[15:11] == 5'h1F;
  wire logic       md = cmd_word[9:5] == 5'h00 || cmd_word[9:5] == 5'h1F;
  wire logic       ud = md && (cmd_word[10] ? (mc == 5'h11 || mc == 5'h14 || mc == 5'h15)
                                            : (mc <= 5'h13 && mc != 5'h11));

  // options lag the snapshot by one cycle, hence the look one edge later
  a_bcast_ignored: assert property (
    cmd_strobe && bc ##1 broadcast_invalid_option |=> !cmd_recognized && !cmd_status_update)
    else $error("broadcast not ignored");
  a_bcast_valid: assert property (
    !$past(cmd_strobe) && cmd_strobe && bc && !ud ##1 !broadcast_invalid_option
    |=> cmd_recognized && !cmd_respond) else $error("broadcast not taken");
  a_undef_ignored: assert property (
    cmd_strobe && ud ##1 undefined_mode_invalid_option |=> !cmd_recognized && !cmd_respond)
    else $error("undefined code not ignored");
  a_msg_error: assert property (
    cmd_recognized |-> cmd_msg_error == $past(cmd_illegal, 2)
    && cmd_status_only == (cmd_respond && $past(cmd_illegal, 2))) else $error("message error");
  a_bcast_store: assert property (
    cmd_recognized |-> cmd_bcast_sep == ($past(bc, 2) && $past(separate_broadcast_data_option)))
    else $error("broadcast store");
  a_simple_mode: assert property (
    cmd_recognized |-> cmd_simplified == ($past(md, 2) && $past(simplified_mode_processing_option)))
    else $error("simplified handling");
  a_pulse_gated: assert property (
    cmd_respond || cmd_status_update || cmd_bcast_sep || cmd_simplified |-> cmd_recognized)
    else $error("pulse without recognition");
  a_opts_reset: assert property (disable iff (1'b0)
    !rstn [*2] |-> !(broadcast_invalid_option || undefined_mode_invalid_option
    || separate_broadcast_data_option || simplified_mode_processing_option))
    else $error("options not cleared");

  cover property (cmd_recognized && cmd_status_only);
  cover property (cmd_bcast_sep);
  cover property (cmd_simplified);
endmodule : rtv_cmd_validate_chk

bind rtv_cmd_validate rtv_cmd_validate_chk u_rtv_cmd_validate_chk (.mclk, .rstn, .cmd_strobe,
  .cmd_word, .cmd_illegal, .cmd_recognized, .cmd_respond, .cmd_status_only, .cmd_msg_error,
  .cmd_status_update, .cmd_bcast_sep, .cmd_simplified, .broadcast_invalid_option,
  .undefined_mode_invalid_option, .separate_broadcast_data_option,
  .simplified_mode_processing_option);

//--- bench/test_rtv_cmd_validate.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module test_rtv_cmd_validate
  import rtv_pkg::*;
;
  logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, er, v;
  logic        host_rd_strobe_n, byte_select_address_bit, host_bus_8bit;
  logic        cmd_strobe, cmd_illegal, cmd_recognized, cmd_respond, cmd_status_only;
  logic        cmd_msg_error, cmd_status_update, cmd_bcast_sep, cmd_simplified;
  logic        broadcast_invalid_option, undefined_mode_invalid_option;
  logic        separate_broadcast_data_option, simplified_mode_processing_option;
  logic        single_strobe_byte_read_option;
  logic [7:0]  paddr, host_rd_byte;
  logic [15:0] cmd_word, host_rd_word, lw;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors, cmp_count, n_rec, n_ign;
  wire logic [4:0] opts = {broadcast_invalid_option, undefined_mode_invalid_option,
    separate_broadcast_data_option, simplified_mode_processing_option,
    single_strobe_byte_read_option};
  localparam logic [15:0] BW = {5'h1F, 1'b0, 5'h03, 5'h04};

  rtv_cmd_validate u_rtv_cmd_validate (.*);
  rtv_bc_model     u_rtv_bc_model (.*);

  always #20 mclk = ~mclk;

  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // pulses are looked at mid-cycle, two edges after the strobe edge
  task automatic cmd(input logic [15:0] w, input logic il, input logic [5:0] ex);
    u_rtv_bc_model.send(w, il);
    @(posedge mclk);
    @(negedge mclk);
    `CHK("pulses", ex, ({cmd_recognized, cmd_respond, cmd_status_only, cmd_status_update,
      cmd_bcast_sep, cmd_simplified}))
    if (ex[5]) begin
      n_rec++;
      lw = w;
    end else
      n_ign++;
  endtask : cmd

  initial begin
    {mclk, rstn, psel, penable, pwrite, host_bus_8bit, byte_select_address_bit} = '0;
    host_rd_strobe_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    host_rd_word = 16'hA55A;
    lw = 16'h0000;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    apb(0, RTV_OFF_CFG, 32'h0);
    `CHK("cfg", 32'h0, rd)
    `CHK("opts", 5'h00, opts)
    apb(1, RTV_OFF_CFG, 32'h1F);
    apb(0, RTV_OFF_CFG, 32'h0);
    `CHK("cfg", 32'h1F, rd)
    `CHK("opts", 5'h1F, opts)
    apb(0, 8'hFC, 32'h0);
    `CHK("slverr", 1'b1, er)
    apb(1, RTV_OFF_RTADDR, 32'h05);
    $display("registers done");
    apb(1, RTV_OFF_CFG, 32'h10);
    cmd(BW, 1'b0, 6'b000000);
    apb(1, RTV_OFF_CFG, 32'h00);
    cmd(BW, 1'b0, 6'b100100);
    apb(1, RTV_OFF_CFG, 32'h04);
    cmd(BW, 1'b1, 6'b100110);
    `CHK("msgerr", 1'b1, cmd_msg_error)
    $display("broadcast done");
    apb(1, RTV_OFF_CFG, 32'h08);
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 22; m++) begin
        v = t ? (m != 17 && m != 20 && m != 21) : (m > 19 || m == 17);
        cmd({5'h05, t[0], (m[0] ? 5'h1F : 5'h00), m[4:0]}, 1'b0, {v, v, 1'b0, v, 2'b00});
      end
    end
    apb(0, RTV_OFF_COUNT, 32'h0);
    `CHK("count", ({n_ign[15:0], n_rec[15:0]}), rd)
    apb(0, RTV_OFF_LASTCMD, 32'h0);
    `CHK("lastcmd", ({16'h0000, lw}), rd)
    $display("undefined codes done");
    apb(1, RTV_OFF_CFG, 32'h00);
    cmd({5'h05, 1'b0, 5'h00, 5'h02}, 1'b1, 6'b111100);
    `CHK("msgerr", 1'b1, cmd_msg_error)
    apb(0, RTV_OFF_VSTAT, 32'h0);
    `CHK("vstat", 32'h5, rd)
    cmd({5'h05, 1'b0, 5'h00, 5'h02}, 1'b0, 6'b110100);
    `CHK("msgerr", 1'b0, cmd_msg_error)
    apb(1, RTV_OFF_CFG, 32'h02);
    cmd({5'h05, 1'b1, 5'h1F, 5'h02}, 1'b0, 6'b110101);
    cmd({5'h05, 1'b1, 5'h07, 5'h02}, 1'b0, 6'b110100);
    $display("mode handling done");
    apb(1, RTV_OFF_CFG, 32'h01);
    host_bus_8bit <= 1'b1;
    host_rd_strobe_n <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("low byte", 8'h5A, host_rd_byte)
    byte_select_address_bit <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("high byte", 8'hA5, host_rd_byte)
    host_rd_strobe_n <= 1'b1;
    apb(1, RTV_OFF_CFG, 32'h00);
    byte_select_address_bit <= 1'b0;
    host_rd_strobe_n <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("dual low", 8'h5A, host_rd_byte)
    byte_select_address_bit <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK("dual hold", 8'h5A, host_rd_byte)
    host_rd_strobe_n <= 1'b1;
    repeat (4) @(posedge mclk);
    host_rd_strobe_n <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("dual high", 8'hA5, host_rd_byte)
    host_rd_strobe_n <= 1'b1;
    $display("byte read done");
    apb(1, RTV_OFF_CFG, 32'h1F);
    repeat (2) @(posedge mclk);
    `CHK("opts", 5'h1F, opts)
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("opts", 5'h00, opts)
    rstn <= 1'b1;
    apb(0, RTV_OFF_CFG, 32'h0);
    `CHK("cfg", 32'h0, rd)
    `CHK("opts", 5'h00, opts)
    $display("reset done");
    conclude();
  end
endmodule : test_rtv_cmd_validate
